// ==== rtl/zoomed_video_router.sv ====
// Purpose: Routes slot A or slot B pixels onto a buffered video port; the external source only drives the buffer switch.
// Assumes: Pixel data stable around its clock's rising edge.
// Notes: Config space dword access at 84h and 8Ch, answer next cycle.
`timescale 1ns/10ps
module zoomed_video_router #(
	parameter int PIXEL_W = video_router_pkg::PIXEL_W,
	parameter int FIFO_DEPTH = video_router_pkg::FIFO_DEPTH,
	parameter int DETECT_CYCLES = video_router_pkg::DETECT_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic cfg_req,
	input wire logic cfg_we,
	input wire logic [7:0] cfg_addr,
	input wire logic [3:0] cfg_be,
	input wire logic [31:0] cfg_wdata,
	output logic [31:0] cfg_rdata,
	output logic cfg_ack,
	input wire logic slot_a_pclk,
	input wire logic [PIXEL_W-1:0] slot_a_pixel,
	input wire logic slot_b_pclk,
	input wire logic [PIXEL_W-1:0] slot_b_pixel,
	input wire logic video_out_ready,
	output logic [PIXEL_W-1:0] video_out_data,
	output logic video_out_strobe,
	output logic video_out_oe,
	output logic overflow,
	input wire logic [4:0] multifunction_pin_in,
	output logic [4:0] multifunction_pin_out,
	output logic [4:0] multifunction_pin_oe
);
	localparam int NP = video_router_pkg::NUM_MF_PINS;
	localparam int CW = $clog2(DETECT_CYCLES + 1);
	localparam logic [CW-1:0] WIN = CW'(DETECT_CYCLES);

	typedef enum logic [1:0] {
		MODE_IDLE = 2'b00,
		MODE_MANUAL = 2'b01,
		MODE_AUTO = 2'b10
	} route_mode_t;

	typedef struct packed {
		logic [7:0] mm;
		logic [31:0] route;
		logic [31:0] rdata;
		logic ack;
		logic [1:0] pclk_s1;
		logic [1:0] pclk_s2;
		logic [PIXEL_W-1:0] a_s1;
		logic [PIXEL_W-1:0] a_s2;
		logic [PIXEL_W-1:0] b_s1;
		logic [PIXEL_W-1:0] b_s2;
		logic [NP-1:0] mf_s1;
		logic [NP-1:0] mf_s2;
		logic [2:0] pclk_prev;
		logic [2:0][CW-1:0] idle_cnt;
		logic [2:0] active;
		logic [1:0] sel;
		route_mode_t mode;
		logic push;
		logic [PIXEL_W-1:0] push_data;
		logic [PIXEL_W-1:0] out_data;
		logic out_stb;
		logic out_oe;
		logic flush;
		logic ovf;
		logic [NP-1:0] mf_out;
		logic [NP-1:0] mf_oe;
	} router_state_t;

	router_state_t s_q;
	router_state_t s_d;

	pixel_stream_if #(.WIDTH(PIXEL_W)) fill_if ();
	pixel_stream_if #(.WIDTH(PIXEL_W)) drain_if ();

	// Sixteen words ride out short downstream stalls
	pixel_fifo #(
		.WIDTH(PIXEL_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.rst(rst),
		.wr(fill_if.sink),
		.rd(drain_if.source)
	);

	assign fill_if.valid = s_q.push;
	assign fill_if.data = s_q.push_data;
	// Downstream stall backs up into the FIFO; a flush drains regardless
	assign drain_if.ready = (video_out_ready && s_q.out_oe) || s_q.flush;

	// Priority table: three source codes, first entry is top priority
	function automatic logic [5:0] prio_order(input logic [2:0] code);
		logic [5:0] o;
		o = {video_router_pkg::SRC_A, video_router_pkg::SRC_B,
			video_router_pkg::SRC_EXT};
		case (code)
			3'h0: o = {video_router_pkg::SRC_A, video_router_pkg::SRC_B,
				video_router_pkg::SRC_EXT};
			3'h1: o = {video_router_pkg::SRC_A, video_router_pkg::SRC_EXT,
				video_router_pkg::SRC_B};
			3'h2: o = {video_router_pkg::SRC_B, video_router_pkg::SRC_A,
				video_router_pkg::SRC_EXT};
			3'h3: o = {video_router_pkg::SRC_B, video_router_pkg::SRC_EXT,
				video_router_pkg::SRC_A};
			3'h4: o = {video_router_pkg::SRC_EXT, video_router_pkg::SRC_A,
				video_router_pkg::SRC_B};
			3'h5, 3'h6: o = {video_router_pkg::SRC_EXT,
				video_router_pkg::SRC_B, video_router_pkg::SRC_A};
			// Reserved code falls back to the first order
			default: o = {video_router_pkg::SRC_A, video_router_pkg::SRC_B,
				video_router_pkg::SRC_EXT};
		endcase
		return o;
	endfunction : prio_order

	logic [2:0] pclk_now;
	logic [2:0] pclk_rise;
	logic sense_lo;
	logic sense_hi;
	logic ext_pclk;
	logic en_a;
	logic en_b;
	logic auto_on;
	logic [5:0] order;
	logic [1:0] pick;
	logic found;
	logic sel_en;
	logic [PIXEL_W-1:0] sel_pixel;
	logic wr84;
	logic wr8c;
	logic [NP-1:0] field_zv;

	// One three-bit routing field per pin
	for (genvar p = 0; p < NP; p++) begin : g_pin_field
		assign field_zv[p] =
			(s_q.route[p*video_router_pkg::MF_FIELD_W +: 3] ==
			video_router_pkg::MF_FIELD_ZV);
	end

	always_comb begin
		s_d = s_q;
		s_d.ack = 1'b0;
		pick = s_q.sel;
		found = 1'b0;
		wr84 = cfg_req && cfg_we &&
			(cfg_addr[7:2] == video_router_pkg::MM_CTRL_OFFSET[7:2]);
		wr8c = cfg_req && cfg_we &&
			(cfg_addr[7:2] == video_router_pkg::MF_ROUTE_OFFSET[7:2]);

		// Config space access: low byte holds the 8-bit control register
		if (wr84 && cfg_be[0]) begin
			s_d.mm = cfg_wdata[7:0];
		end
		// Routing register takes each enabled byte lane on its own
		if (wr8c) begin
			for (int i = 0; i < 4; i++) begin
				if (cfg_be[i]) begin
					s_d.route[i*8 +: 8] = cfg_wdata[i*8 +: 8];
				end
			end
		end
		if (cfg_req) begin
			s_d.ack = 1'b1;
			s_d.rdata = 32'h0000_0000;
			if (!cfg_we) begin
				if (cfg_addr[7:2] == video_router_pkg::MM_CTRL_OFFSET[7:2]) begin
					s_d.rdata = {24'h00_0000, s_q.mm};
					// In auto mode the select bit reports the detected socket
					if (s_q.mode == MODE_AUTO) begin
						s_d.rdata[video_router_pkg::PORT_SEL_BIT] =
							(s_q.sel == video_router_pkg::SRC_B);
					end
				end else if (cfg_addr[7:2] ==
					video_router_pkg::MF_ROUTE_OFFSET[7:2]) begin
					s_d.rdata = s_q.route;
				end
			end
		end

		// Two-flop synchronisers for everything from the pins
		s_d.pclk_s1 = {slot_b_pclk, slot_a_pclk};
		s_d.pclk_s2 = s_q.pclk_s1;
		// Pixel bits need no gray code: they stand still around the edge
		s_d.a_s1 = slot_a_pixel;
		s_d.a_s2 = s_q.a_s1;
		s_d.b_s1 = slot_b_pixel;
		s_d.b_s2 = s_q.b_s1;
		s_d.mf_s1 = multifunction_pin_in;
		s_d.mf_s2 = s_q.mf_s1;

		// External pixel clock sense pin, pin 3 preferred over pin 2
		sense_hi = (s_q.route[video_router_pkg::SENSE_PIN_HI *
			video_router_pkg::MF_FIELD_W +: 3] ==
			video_router_pkg::MF_FIELD_ZV);
		sense_lo = (s_q.route[video_router_pkg::SENSE_PIN_LO *
			video_router_pkg::MF_FIELD_W +: 3] ==
			video_router_pkg::MF_FIELD_ZV);
		if (sense_hi) begin
			ext_pclk = s_q.mf_s2[video_router_pkg::SENSE_PIN_HI];
		end else if (sense_lo) begin
			ext_pclk = s_q.mf_s2[video_router_pkg::SENSE_PIN_LO];
		end else begin
			ext_pclk = 1'b0;
		end
		pclk_now = {ext_pclk, s_q.pclk_s2};
		pclk_rise = pclk_now & ~s_q.pclk_prev;
		s_d.pclk_prev = pclk_now;

		// Activity windows, one per source
		// Counter parks at the window end so it never wraps
		for (int i = 0; i < 3; i++) begin
			if (pclk_rise[i]) begin
				s_d.idle_cnt[i] = '0;
				s_d.active[i] = 1'b1;
			end else if (s_q.idle_cnt[i] != WIN) begin
				s_d.idle_cnt[i] = s_q.idle_cnt[i] + 1'b1;
			end else begin
				s_d.active[i] = 1'b0;
			end
		end

		en_a = s_q.mm[video_router_pkg::SLOT_A_EN_BIT];
		en_b = s_q.mm[video_router_pkg::SLOT_B_EN_BIT];
		auto_on = s_q.mm[video_router_pkg::AUTO_BIT];

		// Source selection; with nothing active the last choice stands
		order = prio_order(s_q.mm[video_router_pkg::PRIO_LSB +: 3]);
		case (s_q.mode)
			MODE_IDLE: begin
				s_d.mode = MODE_MANUAL;
				s_d.sel = video_router_pkg::SRC_A;
			end
			MODE_MANUAL: begin
				s_d.sel = s_q.mm[video_router_pkg::PORT_SEL_BIT] ?
					video_router_pkg::SRC_B : video_router_pkg::SRC_A;
				if (auto_on) begin
					s_d.mode = MODE_AUTO;
				end
			end
			MODE_AUTO: begin
				// Top entry first; the first active source wins
				for (int i = 2; i >= 0; i--) begin
					if (!found && s_q.active[order[i*2 +: 2]]) begin
						pick = order[i*2 +: 2];
						found = 1'b1;
					end
				end
				s_d.sel = pick;
				if (!auto_on) begin
					s_d.mode = MODE_MANUAL;
				end
			end
			default: begin
				s_d.mode = MODE_MANUAL;
				s_d.sel = video_router_pkg::SRC_A;
			end
		endcase
		// Old source words must never reach the port after a switch
		if (s_d.sel != s_q.sel) begin
			s_d.flush = 1'b1;
		end else if (!drain_if.valid && !s_q.push) begin
			s_d.flush = 1'b0;
		end

		// Enable of the routed source; external rides on either card enable
		case (s_q.sel)
			video_router_pkg::SRC_A: begin
				sel_en = en_a;
				sel_pixel = s_q.a_s2;
			end
			video_router_pkg::SRC_B: begin
				sel_en = en_b;
				sel_pixel = s_q.b_s2;
			end
			default: begin
				sel_en = en_a || en_b;
				sel_pixel = '0;
			end
		endcase
		s_d.out_oe = s_q.mm[video_router_pkg::OUT_EN_BIT];

		// Card pixels enter the FIFO on their own clock edge
		s_d.push = 1'b0;
		if (s_q.out_oe && (en_a || en_b) && sel_en &&
			(s_q.sel != video_router_pkg::SRC_EXT) &&
			pclk_rise[s_q.sel]) begin
			s_d.push = 1'b1;
			s_d.push_data = sel_pixel;
		end
		// Clear first so a drop in the same cycle still sets the flag
		if (wr84) begin
			s_d.ovf = 1'b0;
		end
		// Word dropped when the FIFO cannot take it
		if (s_q.push && !fill_if.ready) begin
			s_d.ovf = 1'b1;
		end

		// Output stage; low whenever the routed socket is disabled
		s_d.out_stb = 1'b0;
		if (!s_q.out_oe || !sel_en || !(en_a || en_b) ||
			s_q.flush) begin
			s_d.out_data = '0;
		end else if (drain_if.valid && drain_if.ready) begin
			s_d.out_data = drain_if.data;
			s_d.out_stb = 1'b1;
		end

		// Buffer switch and clock sense pins
		for (int p = 0; p < NP; p++) begin
			// Sense pins stay inputs; only switch pins may drive
			s_d.mf_oe[p] = 1'b0;
			s_d.mf_out[p] = 1'b0;
			if (video_router_pkg::SWITCH_PIN_MASK[p] &&
				field_zv[p]) begin
				s_d.mf_oe[p] = 1'b1;
				s_d.mf_out[p] = s_q.out_oe && (en_a || en_b) &&
					(s_q.sel == video_router_pkg::SRC_EXT);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_q <= '0;
			s_q.mm <= video_router_pkg::MM_CTRL_RESET;
			s_q.route <= video_router_pkg::MF_ROUTE_RESET;
			s_q.sel <= video_router_pkg::SRC_A;
			s_q.mode <= MODE_IDLE;
		end else begin
			s_q <= s_d;
		end
	end

	assign cfg_rdata = s_q.rdata;
	assign cfg_ack = s_q.ack;
	assign video_out_data = s_q.out_data;
	assign video_out_strobe = s_q.out_stb;
	assign video_out_oe = s_q.out_oe;
	assign overflow = s_q.ovf;
	assign multifunction_pin_out = s_q.mf_out;
	assign multifunction_pin_oe = s_q.mf_oe;
endmodule : zoomed_video_router

// ==== rtl/video_router_pkg.sv ====
// Purpose: Shared constants for the zoomed video router.
// Assumes: 250 MHz core clock, dword config access.
// Notes: Per-pin routing fields sit four bits apart.
// Operation
// - One output source always selected; after reset it is socket 0.
// - Video output enable bit turns on the video output terminals.
// - No video data leaves unless slot A or slot B video enable set.
// - Routed socket with its enable cleared drives video outputs low.
// - Auto-detect senses each socket's pixel clock and a third one.
// - Auto-detect switches the source mux itself; select bits unused.
// - Auto-detect is off after reset, giving plain software selection.
// - Writing 1 to control bit 5 at 84h turns auto-detect on.
// - Control bits 4..2 choose source priority order; 111 reserved.
// - Field 111 at 14..12 or 10..8 makes pin 3 or 2 the clock sense.
// - Field 111 at 18..16, 6..4, 2..0 drives buffer switch on 4, 1, 0.
// - Buffer switch output shows that the external source is selected; driven high only while bit 7 and slot A or B enable are set.
package video_router_pkg;
	localparam logic [7:0] MM_CTRL_OFFSET = 8'h84;
	localparam logic [7:0] MF_ROUTE_OFFSET = 8'h8C;
	localparam logic [7:0] MM_CTRL_RESET = 8'h00;
	localparam logic [31:0] MF_ROUTE_RESET = 32'h0000_0000;
	localparam int SLOT_A_EN_BIT = 0;
	localparam int SLOT_B_EN_BIT = 1;
	localparam int PRIO_LSB = 2;
	localparam int AUTO_BIT = 5;
	localparam int PORT_SEL_BIT = 6;
	localparam int OUT_EN_BIT = 7;
	localparam logic [2:0] MF_FIELD_ZV = 3'h7;
	localparam int MF_FIELD_W = 4;
	localparam int NUM_MF_PINS = 5;
	localparam int SENSE_PIN_LO = 2;
	localparam int SENSE_PIN_HI = 3;
	localparam logic [NUM_MF_PINS-1:0] SWITCH_PIN_MASK = 5'h13;
	localparam logic [1:0] SRC_A = 2'h0;
	localparam logic [1:0] SRC_B = 2'h1;
	localparam logic [1:0] SRC_EXT = 2'h2;
	localparam int CLK_MHZ = 250;
	localparam int DETECT_WINDOW_NS = 1000;
	localparam int DETECT_CYCLES = (DETECT_WINDOW_NS * CLK_MHZ + 999) / 1000;
	localparam int PIXEL_W = 16;
	localparam int FIFO_DEPTH = 16;
endpackage : video_router_pkg

// ==== rtl/pixel_stream_if.sv ====
// Purpose: Valid/ready pixel word carrier between router and FIFO.
// Assumes: Single clock domain.
// Notes: Transfer when valid and ready are both high.
`timescale 1ns/10ps
interface pixel_stream_if #(parameter int WIDTH = 16);
	logic valid;
	logic ready;
	logic [WIDTH-1:0] data;
	modport source (output valid, output data, input ready);
	modport sink (input valid, input data, output ready);
endinterface : pixel_stream_if

// ==== rtl/pixel_fifo.sv ====
// Purpose: Flip-flop FIFO buffering pixel words.
// Assumes: Depth is a power of two.
// Notes: Full and empty are exact; no write when full.
`timescale 1ns/10ps
module pixel_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst,
	pixel_stream_if.sink wr,
	pixel_stream_if.source rd
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wptr;
		logic [AW-1:0] rptr;
		logic [AW:0] count;
	} fifo_state_t;
	fifo_state_t s_q;
	fifo_state_t s_d;
	logic do_wr;
	logic do_rd;

	assign wr.ready = (s_q.count != (AW+1)'(DEPTH));
	assign rd.valid = (s_q.count != '0);
	assign rd.data = s_q.mem[s_q.rptr];
	assign do_wr = wr.valid && wr.ready;
	assign do_rd = rd.valid && rd.ready;

	always_comb begin
		s_d = s_q;
		if (do_wr) begin
			s_d.mem[s_q.wptr] = wr.data;
			s_d.wptr = s_q.wptr + 1'b1;
		end
		if (do_rd) begin
			s_d.rptr = s_q.rptr + 1'b1;
		end
		if (do_wr && !do_rd) begin
			s_d.count = s_q.count + 1'b1;
		end else if (do_rd && !do_wr) begin
			s_d.count = s_q.count - 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
endmodule : pixel_fifo

// ==== dv/video_router_assertions.sv ====
// Purpose: Port checks for the zoomed video router.
// Assumes: Bound to every router instance, config access at dword offsets.
// Notes: Output pipeline depths follow the hand-over timing.
`timescale 1ns/10ps
module video_router_assertions #(
	parameter int PIXEL_W = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic cfg_req,
	input wire logic cfg_we,
	input wire logic [7:0] cfg_addr,
	input wire logic [3:0] cfg_be,
	input wire logic [31:0] cfg_wdata,
	input wire logic [31:0] cfg_rdata,
	input wire logic cfg_ack,
	input wire logic video_out_ready,
	input wire logic [PIXEL_W-1:0] video_out_data,
	input wire logic video_out_strobe,
	input wire logic video_out_oe,
	input wire logic [4:0] multifunction_pin_oe
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	a_ack_after_req: assert property (
		cfg_req |=> cfg_ack) else $error("no ack after request");
	a_ack_needs_req: assert property (
		cfg_ack |-> $past(cfg_req)) else $error("ack without request");
	a_write_rdata_zero: assert property (
		cfg_req && cfg_we |=> cfg_rdata == 32'h0)
		else $error("write returned data");
	a_unmapped_reads_zero: assert property (
		cfg_req && !cfg_we && cfg_addr[7:2] != 6'h21 && cfg_addr[7:2] != 6'h23
		|=> cfg_rdata == 32'h0) else $error("unmapped read not zero");
	a_ctrl_upper_zero: assert property (
		cfg_req && !cfg_we && cfg_addr[7:2] == 6'h21
		|=> cfg_rdata[31:8] == 24'h0) else $error("control upper bits set");
	a_oe_follows_bit: assert property (
		cfg_req && cfg_we && cfg_addr[7:2] == 6'h21 && cfg_be[0]
		|=> ##1 video_out_oe == $past(cfg_wdata[7], 2))
		else $error("output enable wrong");
	a_quiet_when_off: assert property (
		!video_out_oe && $past(!video_out_oe) |-> video_out_data == '0)
		else $error("data while output off");
	a_strobe_needs_ready: assert property (
		video_out_strobe |-> $past(video_out_ready))
		else $error("strobe without ready");
	a_sense_pins_undriven: assert property (
		multifunction_pin_oe[3:2] == 2'h0) else $error("sense pin driven");
endmodule : video_router_assertions

bind zoomed_video_router video_router_assertions #(.PIXEL_W(PIXEL_W))
	i_video_router_assertions (.clk(clk), .rst(rst), .cfg_req(cfg_req),
	.cfg_we(cfg_we), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
	.cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack),
	.video_out_ready(video_out_ready), .video_out_data(video_out_data),
	.video_out_strobe(video_out_strobe), .video_out_oe(video_out_oe),
	.multifunction_pin_oe(multifunction_pin_oe));

// ==== dv/slot_video_source.sv ====
// Purpose: Card or board pixel source with its own pixel clock.
// Assumes: 48 ns pixel clock, data moved on its falling edge.
// Notes: Clock stands low between frames; released data is inverted.
`timescale 1ns/10ps
module slot_video_source (
	input wire logic run,
	input wire logic [15:0] base,
	output logic pclk,
	output logic [15:0] pixel
);
	initial begin
		pclk = 1'b0;
		pixel = 16'h0000;
	end
	always begin
		wait (run);
		pixel = base;
		while (run) begin
			#24 pclk = 1'b1;
			#24 pclk = 1'b0;
			// Moved on the fall so it stands 24 ns around each rise
			pixel = pixel + 16'h0001;
		end
		// Stale data must not look like a valid pixel
		pixel = ~pixel;
	end
endmodule : slot_video_source

// ==== dv/tb_top.sv ====
// Purpose: Self-checking bench for the zoomed video router.
// Assumes: Short detection window of 20 cycles for run time.
// Notes: Socket A and board source share the base-count source model.
`timescale 1ns/10ps
module tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cfg_req = 1'b0;
	logic cfg_we = 1'b0;
	logic [7:0] cfg_addr = 8'h00;
	logic [31:0] cfg_wdata = 32'h0;
	logic [31:0] cfg_rdata;
	logic cfg_ack;
	logic ready = 1'b0;
	logic run_a = 1'b0;
	logic run_b = 1'b0;
	logic run_e = 1'b0;
	logic pclk_a, pclk_b, pclk_e;
	logic [15:0] pix_a, pix_b, pix_e, video_out_data;
	logic video_out_strobe, video_out_oe, overflow;
	logic [4:0] pin_out, pin_oe;
	logic [15:0] got [0:31];
	logic [31:0] rd;
	logic [7:0] off [3] = '{8'h80, 8'hC1, 8'h82};
	int n_got = 0;
	int n_mismatch = 0;
	int n_tests = 0;
	int cycles = 0;
	always #2 clk = ~clk;
	zoomed_video_router #(.DETECT_CYCLES(20)) i_zoomed_video_router (
		.clk(clk), .rst(rst), .cfg_req(cfg_req), .cfg_we(cfg_we),
		.cfg_addr(cfg_addr), .cfg_be(4'hF), .cfg_wdata(cfg_wdata),
		.cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .slot_a_pclk(pclk_a),
		.slot_a_pixel(pix_a), .slot_b_pclk(pclk_b), .slot_b_pixel(pix_b),
		.video_out_ready(ready), .video_out_data(video_out_data),
		.video_out_strobe(video_out_strobe), .video_out_oe(video_out_oe),
		.overflow(overflow), .multifunction_pin_in({2'h0, pclk_e, 2'h0}),
		.multifunction_pin_out(pin_out), .multifunction_pin_oe(pin_oe));
	slot_video_source i_slot_video_source_a (.run(run_a), .base(16'h1200),
		.pclk(pclk_a), .pixel(pix_a));
	slot_video_source i_slot_video_source_b (.run(run_b), .base(16'h3400),
		.pclk(pclk_b), .pixel(pix_b));
	slot_video_source i_slot_video_source_e (.run(run_e), .base(16'h5600),
		.pclk(pclk_e), .pixel(pix_e));
	task summarize;
		$display("Mismatches %0d of %0d comparisons", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : summarize
	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	task cfg(input logic we, input logic [7:0] addr, input logic [31:0] wd);
		@(posedge clk);
		cfg_req <= 1'b1;
		cfg_we <= we;
		cfg_addr <= addr;
		cfg_wdata <= wd;
		@(posedge clk);
		cfg_req <= 1'b0;
		@(posedge clk);
		rd = cfg_rdata;
		check({31'h0, cfg_ack}, 32'h1);
	endtask : cfg
	always @(posedge clk) begin
		cycles++;
		if (video_out_strobe === 1'b1 && n_got < 32) begin
			got[n_got] = video_out_data;
			n_got++;
		end
		// Whole run needs under 2000 cycles
		if (cycles == 6000) begin
			n_mismatch++;
			summarize();
		end
	end
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		cfg(1'b0, 8'h84, 32'h0);
		check(rd, 32'h0);
		cfg(1'b0, 8'h8C, 32'h0);
		check(rd, 32'h0);
		cfg(1'b0, 8'h90, 32'h0);
		check(rd, 32'h0);
		cfg(1'b1, 8'h8C, 32'h0007_0777);
		cfg(1'b0, 8'h8C, 32'h0);
		check(rd, 32'h0007_0777);
		check({27'h0, pin_oe}, 32'h13);
		check(32'(video_out_oe), 32'h0);
		ready <= 1'b1;
		run_a <= 1'b1;
		run_b <= 1'b1;
		foreach (off[i]) begin
			cfg(1'b1, 8'h84, {24'h0, off[i]});
			n_got = 0;
			repeat (200) @(posedge clk);
			check(32'(n_got), 32'h0);
			check({16'h0, video_out_data}, 32'h0);
			check(32'(video_out_oe), 32'h1);
		end
		run_a <= 1'b0;
		run_b <= 1'b0;
		ready <= 1'b0;
		repeat (20) @(posedge clk);
		cfg(1'b1, 8'h84, 32'h81);
		n_got = 0;
		run_a <= 1'b1;
		repeat (300) @(posedge clk);
		run_a <= 1'b0;
		repeat (20) @(posedge clk);
		check({31'h0, overflow}, 32'h1);
		ready <= 1'b1;
		repeat (100) @(posedge clk);
		check(32'(n_got), 32'h10);
		for (int i = 0; i < 16; i++)
			check({16'h0, got[i]}, 32'h1200 + 32'(i));
		cfg(1'b1, 8'h84, 32'h81);
		repeat (2) @(posedge clk);
		check({31'h0, overflow}, 32'h0);
		run_a <= 1'b1;
		run_e <= 1'b1;
		for (int p = 0; p < 8; p++) begin
			cfg(1'b1, 8'h84, 32'hA3 | (32'(p) << 2));
			repeat (40) @(posedge clk);
			check(32'(pin_out), p inside {[3:6]} ? 32'h13 : 32'h0);
			cfg(1'b0, 8'h84, 32'h0);
			check(rd, 32'hA3 | (32'(p) << 2));
		end
		cfg(1'b1, 8'h84, 32'hAB);
		run_b <= 1'b1;
		repeat (60) @(posedge clk);
		cfg(1'b0, 8'h84, 32'h0);
		check(rd, 32'hEB);
		run_b <= 1'b0;
		repeat (80) @(posedge clk);
		cfg(1'b0, 8'h84, 32'h0);
		check(rd, 32'hAB);
		summarize();
	end
endmodule : tb_top
